// ### core/port_pin_function_mux.sv
/*
  Port pin function multiplexer: GPIO against analog, reference,
  comparator, timer clock, two two-wire channels and serial programming.
  Assumes the core drives latches, directions and selects on sys_clk;
  pins arrive asynchronously and pass two flip-flops before use.
*/
// Notes on behaviour
// - port A pins analog input or GPIO
// - C0 is LED, reference A or GPIO
// - C1 is LED, comparator A or GPIO
// - C0-C5 weak pull-up only when enabled
// - C3 is LED, GPIO or timer clock
// - enabled change on C4-C7 raises interrupt
// - channel A uses C6 clock, C7 data
// - channel B uses D0 clock, D1 data
// - programmer clocks C6, exchanges data on C7
// - N-channel pull-up off in two-wire mode
// - D2 is GPIO or comparator B
// - two-wire pins never drive actively high
// - D3 is GPIO or reference B
// - D4-D7 analog input or GPIO
// - oscillator pins per internal or crystal mode
// - low master-clear level resets the device
`timescale 1ns/100ps
`default_nettype none
module port_pin_function_mux
  import pinmux_pkg::*;
(
  input  wire logic       sys_clk,
  input  wire logic       resetn,
  input  wire logic [3:0] port_a_in,
  input  wire logic [3:0] port_a_latch,
  input  wire logic [3:0] port_a_dir,
  input  wire logic [3:0] port_a_analog_sel,
  output logic      [3:0] port_a_out,
  output logic      [3:0] port_a_oe,
  output logic      [3:0] port_a_read,
  output logic      [3:0] port_a_analog_connect,
  input  wire logic [7:0] port_c_in,
  input  wire logic [7:0] port_c_latch,
  input  wire logic [7:0] port_c_dir,
  input  wire logic [5:0] port_c_led_sel,
  input  wire logic [5:0] port_c_pullup_en,
  input  wire logic       ref_a_sel,
  input  wire logic       cmp_a_sel,
  input  wire logic       comparator_a_level,
  input  wire logic       timer_clk_sel,
  output logic      [7:0] port_c_out,
  output logic      [7:0] port_c_oe,
  output logic      [7:0] port_c_read,
  output logic      [5:0] port_c_weak_pullup_on,
  output logic      [5:0] port_c_high_current,
  output logic      [1:0] port_c_npu_on,
  output logic            port_c_pin0_reference_a_out,
  output logic            port_c_pin3_timer_ext_clock,
  input  wire logic       pin_change_en,
  input  wire logic       pin_change_clear,
  output logic            pin_change_irq,
  input  wire logic       chan_a_en,
  input  wire logic       serial_clock_channel_a_pull_low,
  input  wire logic       serial_data_channel_a_pull_low,
  output logic            serial_clock_channel_a_level,
  output logic            serial_data_channel_a_level,
  input  wire logic       prog_mode,
  input  wire logic       prog_data_out,
  input  wire logic       prog_data_oe,
  output logic            prog_clock_level,
  output logic            prog_data_level,
  input  wire logic [7:0] port_d_in,
  input  wire logic [7:0] port_d_latch,
  input  wire logic [7:0] port_d_dir,
  input  wire logic [7:4] port_d_analog_sel,
  input  wire logic       cmp_b_sel,
  input  wire logic       comparator_b_level,
  input  wire logic       ref_b_sel,
  output logic      [7:0] port_d_out,
  output logic      [7:0] port_d_oe,
  output logic      [7:0] port_d_read,
  output logic      [7:4] port_d_analog_connect,
  output logic      [1:0] port_d_npu_on,
  output logic            port_d_pin3_reference_b_out,
  input  wire logic       chan_b_en,
  input  wire logic       serial_clock_channel_b_pull_low,
  input  wire logic       serial_data_channel_b_pull_low,
  output logic            serial_clock_channel_b_level,
  output logic            serial_data_channel_b_level,
  input  wire logic       osc_internal_mode,
  input  wire logic       osc_in_or_button_input,
  input  wire logic       osc_out_latch,
  output logic            osc_button_read,
  output logic            osc_in_weak_pullup_on,
  output logic            osc_out_or_general_output,
  output logic            osc_out_oe,
  input  wire logic       button_irq_en,
  input  wire logic       button_clear,
  output logic            button_irq,
  input  wire logic       master_clear_low_input,
  output logic            device_reset_n
);
  // ----------------------------------------------------------------
  // open-drain/npu pin: returns {oe, npu}; output data is always low
  // ----------------------------------------------------------------
  function automatic logic [1:0] npu_pin(input logic tw, input logic pull_low,
                                         input logic latch, input logic dir);
    if (tw)
      npu_pin = {pull_low, 1'b0};
    else
      npu_pin = {dir & ~latch, dir & latch};
  endfunction

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [3:0] sa1_ff, sa2_ff, a_out_ff, a_oe_ff, a_an_ff;
  logic [7:0] sc1_ff, sc2_ff, c_out_ff, c_oe_ff;
  logic [7:0] sd1_ff, sd2_ff, d_out_ff, d_oe_ff;
  logic [7:4] d_an_ff;
  logic [5:0] c_pu_ff, c_hc_ff;
  logic [1:0] c_npu_ff, d_npu_ff;
  logic [7:4] chg_prev_ff;
  logic [3:0] nxt_a_out, nxt_a_oe;
  logic [7:0] nxt_c_out, nxt_c_oe, nxt_d_out, nxt_d_oe;
  logic [1:0] nxt_c_npu, nxt_d_npu, pin6, pin7, pin0, pin1;
  logic       ref_a_ff, ref_b_ff, tmr_ff, chg_ff, nxt_chg;
  logic       so1_ff, so2_ff, btn_prev_ff, btn_ff, nxt_btn;
  logic       mc1_ff, mc2_ff, osc_out_ff, osc_oe_ff, osc_pu_ff;
  logic       tw_a, tw_b;

  // ----------------------------------------------------------------
  // next values
  // ----------------------------------------------------------------
  always_comb
  begin
    tw_a = chan_a_en & ~prog_mode;
    tw_b = chan_b_en;
    nxt_a_out = port_a_latch;
    nxt_a_oe  = port_a_dir & ~port_a_analog_sel;
    nxt_c_out = port_c_latch;
    nxt_c_oe  = port_c_dir;
    if (ref_a_sel)
    begin
      nxt_c_oe[C_REF_A_POS] = 1'b0;
    end
    if (cmp_a_sel)
    begin
      nxt_c_oe[C_CMP_A_POS]  = 1'b1;
      nxt_c_out[C_CMP_A_POS] = comparator_a_level;
    end
    if (timer_clk_sel)
    begin
      nxt_c_oe[C_TMR_POS] = 1'b0;
    end
    pin6 = npu_pin(tw_a, serial_clock_channel_a_pull_low,
                   port_c_latch[C_SCL_POS], port_c_dir[C_SCL_POS]);
    pin7 = npu_pin(tw_a, serial_data_channel_a_pull_low,
                   port_c_latch[C_SDA_POS], port_c_dir[C_SDA_POS]);
    if (prog_mode)
    begin
      pin6 = 2'b00;
      pin7 = {prog_data_oe & ~prog_data_out, prog_data_oe & prog_data_out};
    end
    nxt_c_oe[C_SCL_POS]  = pin6[1];
    nxt_c_oe[C_SDA_POS]  = pin7[1];
    nxt_c_out[C_SCL_POS] = 1'b0;
    nxt_c_out[C_SDA_POS] = 1'b0;
    nxt_c_npu = {pin7[0], pin6[0]};
    nxt_d_out = port_d_latch;
    nxt_d_oe  = port_d_dir;
    nxt_d_oe[7:4] = port_d_dir[7:4] & ~port_d_analog_sel;
    if (cmp_b_sel)
    begin
      nxt_d_oe[D_CMP_B_POS]  = 1'b1;
      nxt_d_out[D_CMP_B_POS] = comparator_b_level;
    end
    if (ref_b_sel)
    begin
      nxt_d_oe[D_REF_B_POS] = 1'b0;
    end
    pin0 = npu_pin(tw_b, serial_clock_channel_b_pull_low,
                   port_d_latch[D_SCL_POS], port_d_dir[D_SCL_POS]);
    pin1 = npu_pin(tw_b, serial_data_channel_b_pull_low,
                   port_d_latch[D_SDA_POS], port_d_dir[D_SDA_POS]);
    nxt_d_oe[D_SCL_POS]  = pin0[1];
    nxt_d_oe[D_SDA_POS]  = pin1[1];
    nxt_d_out[D_SCL_POS] = 1'b0;
    nxt_d_out[D_SDA_POS] = 1'b0;
    nxt_d_npu = {pin1[0], pin0[0]};
    // set wins over clear
    nxt_chg = (chg_ff & ~pin_change_clear)
            | (pin_change_en & (sc2_ff[7:4] != chg_prev_ff));
    nxt_btn = (btn_ff & ~button_clear)
            | (button_irq_en & osc_internal_mode & btn_prev_ff & ~so2_ff);
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      sa1_ff <= RST_4; sa2_ff <= RST_4; a_out_ff <= RST_4;
      a_oe_ff <= RST_4; a_an_ff <= RST_4;
      sc1_ff <= RST_8; sc2_ff <= RST_8; c_out_ff <= RST_8; c_oe_ff <= RST_8;
      sd1_ff <= RST_8; sd2_ff <= RST_8; d_out_ff <= RST_8; d_oe_ff <= RST_8;
      d_an_ff <= RST_4; c_pu_ff <= RST_6; c_hc_ff <= RST_6;
      c_npu_ff <= RST_2; d_npu_ff <= RST_2; chg_prev_ff <= RST_4;
      ref_a_ff <= RST_1; ref_b_ff <= RST_1; tmr_ff <= RST_1; chg_ff <= RST_1;
      so1_ff <= RST_1; so2_ff <= RST_1; btn_prev_ff <= RST_1; btn_ff <= RST_1;
      mc1_ff <= RST_1; mc2_ff <= RST_1;
      osc_out_ff <= RST_1; osc_oe_ff <= RST_1; osc_pu_ff <= RST_1;
    end
    else
    begin
      sa1_ff <= port_a_in; sa2_ff <= sa1_ff;
      sc1_ff <= port_c_in; sc2_ff <= sc1_ff;
      sd1_ff <= port_d_in; sd2_ff <= sd1_ff;
      so1_ff <= osc_in_or_button_input; so2_ff <= so1_ff;
      mc1_ff <= master_clear_low_input; mc2_ff <= mc1_ff;
      a_out_ff <= nxt_a_out; a_oe_ff <= nxt_a_oe;
      a_an_ff <= port_a_analog_sel;
      c_out_ff <= nxt_c_out; c_oe_ff <= nxt_c_oe; c_npu_ff <= nxt_c_npu;
      d_out_ff <= nxt_d_out; d_oe_ff <= nxt_d_oe; d_npu_ff <= nxt_d_npu;
      d_an_ff <= port_d_analog_sel;
      c_pu_ff <= port_c_pullup_en;
      c_hc_ff <= port_c_led_sel & nxt_c_oe[5:0];
      ref_a_ff <= ref_a_sel;
      ref_b_ff <= ref_b_sel;
      tmr_ff <= timer_clk_sel & sc2_ff[C_TMR_POS];
      chg_prev_ff <= sc2_ff[7:4];
      chg_ff <= nxt_chg;
      btn_prev_ff <= so2_ff;
      btn_ff <= nxt_btn;
      osc_out_ff <= osc_internal_mode & osc_out_latch;
      osc_oe_ff <= osc_internal_mode;
      osc_pu_ff <= osc_internal_mode;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign port_a_out = a_out_ff;
  assign port_a_oe = a_oe_ff;
  assign port_a_read = sa2_ff & ~a_an_ff;
  assign port_a_analog_connect = a_an_ff;
  assign port_c_out = c_out_ff;
  assign port_c_oe = c_oe_ff;
  assign port_c_read = sc2_ff;
  assign port_c_weak_pullup_on = c_pu_ff;
  assign port_c_high_current = c_hc_ff;
  assign port_c_npu_on = c_npu_ff;
  assign port_c_pin0_reference_a_out = ref_a_ff;
  assign port_c_pin3_timer_ext_clock = tmr_ff;
  assign pin_change_irq = chg_ff;
  assign serial_clock_channel_a_level = sc2_ff[C_SCL_POS];
  assign serial_data_channel_a_level = sc2_ff[C_SDA_POS];
  assign prog_clock_level = sc2_ff[C_SCL_POS];
  assign prog_data_level = sc2_ff[C_SDA_POS];
  assign port_d_out = d_out_ff;
  assign port_d_oe = d_oe_ff;
  assign port_d_read = {sd2_ff[7:4] & ~d_an_ff, sd2_ff[3:0]};
  assign port_d_analog_connect = d_an_ff;
  assign port_d_npu_on = d_npu_ff;
  assign port_d_pin3_reference_b_out = ref_b_ff;
  assign serial_clock_channel_b_level = sd2_ff[D_SCL_POS];
  assign serial_data_channel_b_level = sd2_ff[D_SDA_POS];
  assign osc_button_read = so2_ff;
  assign osc_in_weak_pullup_on = osc_pu_ff;
  assign osc_out_or_general_output = osc_out_ff;
  assign osc_out_oe = osc_oe_ff;
  assign button_irq = btn_ff;
  assign device_reset_n = mc2_ff;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  analog_a_off_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    1 |=> ((port_a_oe & $past(port_a_analog_sel)) == 4'h0))
    else $error("analog port A pin driven");
  ref_a_pin_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    ref_a_sel |=> !port_c_oe[0] && port_c_pin0_reference_a_out)
    else $error("reference A pin not released");
  cmp_a_drive_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    cmp_a_sel |=> port_c_oe[1] && port_c_out[1] == $past(comparator_a_level))
    else $error("comparator A not on pin");
  timer_clk_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    $past(timer_clk_sel) |-> port_c_pin3_timer_ext_clock == $past(port_c_in[3], 3))
    else $error("timer clock path wrong");
  change_irq_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    (pin_change_en && port_c_in[4] != $past(port_c_in[4]))
    ##1 (pin_change_en && !pin_change_clear)[*3] |-> ##[0:2] pin_change_irq)
    else $error("pin change not flagged");
  change_hold_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    pin_change_irq && !pin_change_clear |=> pin_change_irq)
    else $error("change flag dropped");
  npu_off_tw_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    chan_b_en |=> port_d_npu_on == 2'b00)
    else $error("npu active in two-wire mode");
  no_high_drive_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    chan_a_en && !prog_mode |=> port_c_out[7:6] == 2'b00
                                && port_c_oe[6] == $past(serial_clock_channel_a_pull_low))
    else $error("two-wire pin driven high");
  cmp_b_drive_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    cmp_b_sel |=> port_d_oe[2] && port_d_out[2] == $past(comparator_b_level))
    else $error("comparator B not on pin");
  prog_pins_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    prog_mode |=> !port_c_oe[6] && port_c_npu_on[0] == 1'b0)
    else $error("programming clock pin driven");
  osc_xtal_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    !osc_internal_mode |=> !osc_out_oe && !osc_in_weak_pullup_on)
    else $error("oscillator pin misused in crystal mode");
  mclr_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    !master_clear_low_input [*3] |-> !device_reset_n)
    else $error("master clear ignored");
  cover_tw_a_c: cover property (@(posedge sys_clk) disable iff (!resetn)
    chan_a_en ##1 port_c_oe[7]);
  cover_change_c: cover property (@(posedge sys_clk) disable iff (!resetn)
    $rose(pin_change_irq) ##[1:4] pin_change_clear);
  cover_prog_c: cover property (@(posedge sys_clk) disable iff (!resetn)
    prog_mode && prog_data_oe ##1 port_c_npu_on[1]);
endmodule
`default_nettype wire

// ### core/pinmux_pkg.sv
/*
  Constants for the port pin function multiplexer: pin positions,
  reset values and synchroniser depth.
  Assumes a single core clock and an active-low asynchronous reset.
*/
package pinmux_pkg;
  // ----------------------------------------------------------------
  // pin positions
  // ----------------------------------------------------------------
  localparam int C_REF_A_POS = 0;
  localparam int C_CMP_A_POS = 1;
  localparam int C_TMR_POS   = 3;
  localparam int C_SCL_POS   = 6;
  localparam int C_SDA_POS   = 7;
  localparam int D_SCL_POS   = 0;
  localparam int D_SDA_POS   = 1;
  localparam int D_CMP_B_POS = 2;
  localparam int D_REF_B_POS = 3;
  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [3:0] RST_4 = 4'h0;
  localparam logic [7:0] RST_8 = 8'h00;
  localparam logic [5:0] RST_6 = 6'h00;
  localparam logic [1:0] RST_2 = 2'h0;
  localparam logic       RST_1 = 1'b0;
  // a pin input reaches logic this many edges after it changes
  localparam int SYNC_DEPTH = 2;
endpackage

// ### tb/pin_board.sv
/*
  Board model around one port: resolves each pin's wire level.
  Assumes outputs, enables and pull controls come from the pin multiplexer,
  and that the bench drives the external parties through ext_en and ext_val.
*/
`timescale 1ns/100ps
`default_nettype none
module pin_board #(
  parameter int W = 8
) (
  input  wire logic         clk,
  input  wire logic [W-1:0] out,
  input  wire logic [W-1:0] oe,
  input  wire logic [W-1:0] pull,
  input  wire logic [W-1:0] ext_en,
  input  wire logic [W-1:0] ext_val,
  output logic      [W-1:0] pin
);
  // ----------------------------------------------------------------
  // wire resolution
  // ----------------------------------------------------------------
  logic [W-1:0] float_ff = '0;
  // undriven and unpulled pins wander every cycle
  always @(posedge clk) float_ff <= ~float_ff;
  always_comb
  begin
    for (int i = 0; i < W; i++)
    begin
      if (oe[i])
        pin[i] = out[i];
      else if (ext_en[i])
        pin[i] = ext_val[i];
      else if (pull[i])
        pin[i] = 1'b1;
      else
        pin[i] = float_ff[i];
    end
  end
endmodule
`default_nettype wire

// ### tb/port_pin_function_mux_tb.sv
/*
  Self-checking bench for the port pin function multiplexer.
  Assumes inputs change at the falling edge and pins resolve in pin_board.
*/
`timescale 1ns/100ps
`default_nettype none
module port_pin_function_mux_tb;
  import pinmux_pkg::*;
  logic       sys_clk, resetn;
  logic [3:0] port_a_in, port_a_latch, port_a_dir, port_a_analog_sel;
  logic [3:0] port_a_out, port_a_oe, port_a_read, port_a_analog_connect;
  logic [7:0] port_c_in, port_c_latch, port_c_dir, port_c_out, port_c_oe, port_c_read;
  logic [7:0] port_d_in, port_d_latch, port_d_dir, port_d_out, port_d_oe, port_d_read;
  logic [5:0] port_c_led_sel, port_c_pullup_en, port_c_weak_pullup_on, port_c_high_current;
  logic [7:4] port_d_analog_sel, port_d_analog_connect;
  logic [1:0] port_c_npu_on, port_d_npu_on, bus_a_pull, bus_b_pull;
  logic [3:0] ext_a_en, ext_a_val;
  logic [7:0] ext_c_en, ext_c_val, ext_d_en, ext_d_val;
  logic       ref_a_sel, cmp_a_sel, comparator_a_level, timer_clk_sel, pin_change_en;
  logic       pin_change_clear, chan_a_en, serial_clock_channel_a_pull_low;
  logic       serial_data_channel_a_pull_low, prog_mode, prog_data_out, prog_data_oe;
  logic       cmp_b_sel, comparator_b_level, ref_b_sel, chan_b_en, osc_internal_mode;
  logic       serial_clock_channel_b_pull_low, serial_data_channel_b_pull_low;
  logic       osc_in_or_button_input, osc_out_latch, button_irq_en, button_clear;
  logic       master_clear_low_input, port_c_pin0_reference_a_out, port_c_pin3_timer_ext_clock;
  logic       pin_change_irq, serial_clock_channel_a_level, serial_data_channel_a_level;
  logic       prog_clock_level, prog_data_level, port_d_pin3_reference_b_out;
  logic       serial_clock_channel_b_level, serial_data_channel_b_level, osc_button_read;
  logic       osc_in_weak_pullup_on, osc_out_or_general_output, osc_out_oe, button_irq;
  logic       device_reset_n;
  int         num_errors = 0;
  int         tests_run = 0;
  int         cycles = 0;

  port_pin_function_mux uut (.*);
  pin_board #(.W(4)) brd_a (.clk(sys_clk), .out(port_a_out), .oe(port_a_oe), .pull(4'h0),
    .ext_en(ext_a_en), .ext_val(ext_a_val), .pin(port_a_in));
  pin_board #(.W(8)) brd_c (.clk(sys_clk), .out(port_c_out), .oe(port_c_oe),
    .pull({bus_a_pull | port_c_npu_on, port_c_weak_pullup_on}),
    .ext_en(ext_c_en), .ext_val(ext_c_val), .pin(port_c_in));
  pin_board #(.W(8)) brd_d (.clk(sys_clk), .out(port_d_out), .oe(port_d_oe),
    .pull({6'h00, bus_b_pull | port_d_npu_on}),
    .ext_en(ext_d_en), .ext_val(ext_d_val), .pin(port_d_in));

  // ----------------------------------------------------------------
  // clock, timeout and helpers
  // ----------------------------------------------------------------
  initial
  begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end

  task automatic close_out();
    $display("checks %0d, mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  always @(posedge sys_clk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      num_errors++;
      close_out();
    end
  end

  task automatic step(input int n);
    repeat (n) @(negedge sys_clk);
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      num_errors++;
      $display("wrong value at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  initial
  begin
    {ref_a_sel, cmp_a_sel, comparator_a_level, timer_clk_sel, pin_change_en, pin_change_clear,
     chan_a_en, serial_clock_channel_a_pull_low, serial_data_channel_a_pull_low, prog_mode,
     prog_data_out, prog_data_oe, cmp_b_sel, comparator_b_level, ref_b_sel, chan_b_en,
     serial_clock_channel_b_pull_low, serial_data_channel_b_pull_low, osc_internal_mode,
     osc_out_latch, button_irq_en, button_clear, resetn} = '0;
    {port_a_latch, port_a_dir, port_a_analog_sel, port_c_latch, port_c_dir, port_d_latch,
     port_d_dir, port_c_led_sel, port_c_pullup_en, port_d_analog_sel} = '0;
    {ext_a_val, ext_c_val, ext_d_val, bus_a_pull, bus_b_pull} = '0;
    {ext_a_en, ext_c_en, ext_d_en} = '1;
    master_clear_low_input = 1'b1;
    osc_in_or_button_input = 1'b1;
    step(3);
    resetn = 1'b1;
    step(4);
    chk(8'(device_reset_n), 8'h1);
    // analog against digital on ports a and d
    port_a_analog_sel = 4'h5;
    port_a_dir = 4'h3;
    port_a_latch = 4'hf;
    ext_a_val = 4'ha;
    port_d_analog_sel = 4'h9;
    port_d_dir = 8'hf0;
    port_d_latch = 8'hf0;
    ext_d_val = 8'hf0;
    step(4);
    chk(8'(port_a_analog_connect), 8'h05);
    chk(8'({port_a_oe, port_a_out[1]}), 8'h05);
    chk(8'(port_a_read), 8'h0a);
    chk(8'(port_d_analog_connect), 8'h09);
    chk(8'(port_d_read[7:4]), 8'h06);
    chk(8'(port_d_oe[7:4]), 8'h06);
    // gpio, led drive and weak pull-ups on port c
    port_c_pullup_en = 6'h2a;
    port_c_led_sel = 6'h3f;
    port_c_dir = 8'h0f;
    port_c_latch = 8'h05;
    ext_c_en = 8'hdf;
    step(4);
    chk(8'(port_c_weak_pullup_on), 8'h2a);
    chk(8'(port_c_high_current), 8'h0f);
    chk(8'(port_c_oe[5:0]), 8'h0f);
    chk(8'(port_c_out[3:0]), 8'h05);
    chk(8'(port_c_read[5]), 8'h1);
    ext_c_en = 8'hff;
    // alternate outputs override the latch
    ref_a_sel = 1'b1;
    cmp_a_sel = 1'b1;
    comparator_a_level = 1'b1;
    cmp_b_sel = 1'b1;
    ref_b_sel = 1'b1;
    port_d_dir = 8'h04;
    port_d_latch = 8'h04;
    step(2);
    chk(8'({port_c_oe[1], port_c_out[1]}), 8'h3);
    chk(8'(port_c_pin0_reference_a_out), 8'h1);
    chk(8'({port_d_oe[2], port_d_out[2]}), 8'h2);
    chk(8'(port_d_pin3_reference_b_out), 8'h1);
    {ref_a_sel, cmp_a_sel, cmp_b_sel, ref_b_sel} = 4'h0;
    step(2);
    chk(8'({port_c_out[1], port_d_out[2]}), 8'h1);
    chk(8'({port_c_pin0_reference_a_out, port_d_pin3_reference_b_out}), 8'h0);
    // timer clock input on c3
    timer_clk_sel = 1'b1;
    ext_c_val[3] = 1'b1;
    step(4);
    chk(8'({port_c_oe[3], port_c_pin3_timer_ext_clock}), 8'h1);
    ext_c_val[3] = 1'b0;
    step(4);
    chk(8'(port_c_pin3_timer_ext_clock), 8'h0);
    timer_clk_sel = 1'b0;
    ext_c_val[3] = 1'b1;
    step(4);
    chk(8'(port_c_pin3_timer_ext_clock), 8'h0);
    // pin-change interrupt on c4 to c7
    port_c_dir = 8'h00;
    pin_change_en = 1'b1;
    pin_change_clear = 1'b1;
    step(4);
    pin_change_clear = 1'b0;
    step(1);
    for (int i = 4; i < 8; i++)
    begin
      ext_c_val[i] = ~ext_c_val[i];
      step(2);
      chk(8'(pin_change_irq), 8'h0);
      step(3);
      chk(8'(pin_change_irq), 8'h1);
      pin_change_clear = 1'b1;
      step(1);
      pin_change_clear = 1'b0;
      chk(8'(pin_change_irq), 8'h0);
    end
    pin_change_en = 1'b0;
    ext_c_val[4] = ~ext_c_val[4];
    step(5);
    chk(8'(pin_change_irq), 8'h0);
    // two-wire channel a on c6/c7
    ext_c_en = 8'h3f;
    bus_a_pull = 2'h3;
    port_c_latch = 8'hc0;
    port_c_dir = 8'hc0;
    chan_a_en = 1'b1;
    serial_clock_channel_a_pull_low = 1'b1;
    step(4);
    chk(8'(port_c_oe[7:6]), 8'h1);
    chk(8'(port_c_out[7:6]), 8'h0);
    chk(8'(port_c_npu_on), 8'h0);
    chk(8'({serial_clock_channel_a_level, serial_data_channel_a_level}), 8'h1);
    serial_clock_channel_a_pull_low = 1'b0;
    serial_data_channel_a_pull_low = 1'b1;
    step(4);
    chk(8'(port_c_oe[7:6]), 8'h2);
    chk(8'({serial_clock_channel_a_level, serial_data_channel_a_level}), 8'h2);
    chan_a_en = 1'b0;
    step(4);
    chk(8'(port_c_npu_on), 8'h3);
    // two-wire channel b on d0/d1
    ext_d_en = 8'hfc;
    bus_b_pull = 2'h3;
    port_d_latch = 8'h03;
    port_d_dir = 8'h03;
    chan_b_en = 1'b1;
    serial_clock_channel_b_pull_low = 1'b1;
    step(4);
    chk(8'(port_d_oe[1:0]), 8'h1);
    chk(8'({port_d_out[1:0], port_d_npu_on}), 8'h0);
    chk(8'({serial_clock_channel_b_level, serial_data_channel_b_level}), 8'h1);
    serial_clock_channel_b_pull_low = 1'b0;
    serial_data_channel_b_pull_low = 1'b1;
    step(4);
    chk(8'({port_d_oe[1:0], serial_clock_channel_b_level, serial_data_channel_b_level}), 8'h0a);
    // serial programming takes c6/c7 over channel a
    ext_c_en = 8'h7f;
    ext_c_val[6] = 1'b1;
    chan_a_en = 1'b1;
    serial_clock_channel_a_pull_low = 1'b1;
    prog_mode = 1'b1;
    step(4);
    chk(8'(port_c_oe[7:6]), 8'h0);
    chk(8'({prog_clock_level, prog_data_level}), 8'h3);
    prog_data_oe = 1'b1;
    step(4);
    chk(8'({port_c_oe[7], port_c_out[7], prog_data_level}), 8'h4);
    prog_data_out = 1'b1;
    step(4);
    chk(8'({port_c_npu_on[1], port_c_out[7]}), 8'h2);
    // oscillator pins and button interrupt
    osc_internal_mode = 1'b1;
    osc_out_latch = 1'b1;
    button_irq_en = 1'b1;
    step(4);
    chk(8'({osc_in_weak_pullup_on, osc_out_or_general_output, osc_out_oe}), 8'h7);
    osc_in_or_button_input = 1'b0;
    step(4);
    chk(8'({osc_button_read, button_irq}), 8'h1);
    button_clear = 1'b1;
    step(1);
    button_clear = 1'b0;
    chk(8'(button_irq), 8'h0);
    osc_internal_mode = 1'b0;
    step(4);
    chk(8'(osc_in_weak_pullup_on), 8'h0);
    // master clear pin
    master_clear_low_input = 1'b0;
    step(3);
    chk(8'(device_reset_n), 8'h0);
    master_clear_low_input = 1'b1;
    step(3);
    chk(8'(device_reset_n), 8'h1);
    close_out();
  end
endmodule
`default_nettype wire
